// ### fdo_defines.svh
// Purpose: offsets, field positions and reset values of the drive control outputs
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes:   definitions only
`ifndef FDO_DEFINES_SVH
`define FDO_DEFINES_SVH

// register byte offsets
`define FDO_OFS_DIG_OUT    5'h00
`define FDO_OFS_CFG_CTL    5'h04
`define FDO_OFS_RATE_SEL   5'h08
`define FDO_OFS_CFG        5'h0C
`define FDO_OFS_HEAD       5'h10
`define FDO_OFS_STAT       5'h14

// digital_output_reg fields
`define FDO_DIG_OUT_SEL_LO 0
`define FDO_DIG_OUT_MTR_LO 4

// disk_controller configuration register fields
`define FDO_CFG_DENS_POL   5
`define FDO_CFG_ENC4       7

// head control register fields
`define FDO_HEAD_SEEK      0
`define FDO_HEAD_IN        1
`define FDO_HEAD_RW        2

// rate codes that count as high density
`define FDO_RATE_500K      2'h0
`define FDO_RATE_1M        2'h3

// reset values
`define FDO_DIG_OUT_RST    8'h00
`define FDO_CFG_RST        8'h20
`define FDO_RATE_RST       2'h0
`define FDO_HEAD_RST       3'h0

`endif

// ### fdo_pkg.sv
// Purpose: shared types of the drive control outputs
// Assumes: nothing beyond the defines header
// Notes:   the pin bundle travels as one packed struct
`default_nettype none
package fdo_pkg;

   // pins toward the drive cable, all active low except density and rate bit
   typedef struct packed {
      logic [1:0] drive_select_outs_n;
      logic [1:0] motor_outs_n;
      logic       density_select_out;
      logic       head_dir_n;
      logic       rate_bit0_out;
   } fdo_pins_t;

   // inactive levels of the pins after reset
   localparam fdo_pins_t FDO_PINS_IDLE = '{
      drive_select_outs_n: 2'h3,
      motor_outs_n:        2'h3,
      density_select_out:  1'b0,
      head_dir_n:          1'b1,
      rate_bit0_out:       1'b0
   };

endpackage : fdo_pkg
`default_nettype wire

// ### fdo_drive_decode.sv
// Purpose: drive select and motor decode from digital_output_reg
// Assumes: caller registers the result
// Notes:   purely combinational
`default_nettype none
`include "fdo_defines.svh"
module fdo_drive_decode (
   // control
   input  wire logic [7:0] dig_out,
   input  wire logic       enc4,
   // decoded, active low
   output logic [1:0]      sel_n,
   output logic [1:0]      mtr_n
);
   logic [1:0] drv;
   logic [3:0] mtr_en;

   assign drv    = dig_out[`FDO_DIG_OUT_SEL_LO +: 2];
   assign mtr_en = dig_out[`FDO_DIG_OUT_MTR_LO +: 4];

   // normal mode: one line per drive, drives 2 and 3 have no select line
   // encoded mode: the drive number on the select pair, its motor on both motor lines
   always_comb begin
      if (enc4) begin
         sel_n = ~drv;
         mtr_n = {2{~mtr_en[drv]}};
      end else begin
         sel_n = ~{drv == 2'h1, drv == 2'h0};
         mtr_n = ~mtr_en[1:0];
      end
   end
endmodule : fdo_drive_decode
`default_nettype wire

// ### fdo_drive_ctrl.sv
// Purpose: drive cable outputs of the disk_controller with an Avalon-MM register slave
// Assumes: clk at 125 MHz, reset synchronous active high, master holds requests
// Notes:   every pin is registered one edge after the register that feeds it
// Notes on behaviour
// - density pin shows high or low rate
// - config bit 5 cleared inverts density pin sense
// - seek drives direction: asserted in, deasserted out
// - direction inactive during read or write
// - two active-low selects from output register bits
// - config bit 7 encodes selects with motors
// - rate bit follows last written rate register
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`default_nettype none
`include "fdo_defines.svh"
module fdo_drive_ctrl (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // avalon-mm slave
   input  wire logic [4:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [3:0]        avs_byteenable,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // drive cable
   output fdo_pkg::fdo_pins_t     pins
);

   logic [7:0]  dig_out_q;
   logic [7:0]  cfg_q;
   logic [1:0]  rate_q;
   logic [2:0]  head_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        wr_go;
   logic        lane0;
   logic [1:0]  sel_n;
   logic [1:0]  mtr_n;
   logic        dir_n;
   fdo_pkg::fdo_pins_t pins_d;
   fdo_pkg::fdo_pins_t pins_q;

   // high density covers 500 Kbps and 1 Mbps
   function automatic logic is_high_rate(input logic [1:0] r);
      is_high_rate = (r == `FDO_RATE_500K) || (r == `FDO_RATE_1M);
   endfunction : is_high_rate

   // one wait cycle on every access: read data is registered before release
   always_ff @(posedge clk) begin
      if (reset)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read || avs_write) && !ack_q;
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_go           = avs_write && ack_q;
   assign lane0           = avs_byteenable[0];

   // read mux, captured in the wait cycle; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (reset)
         rdata_q <= 32'h0000_0000;
      else if (avs_read && !ack_q) begin
         unique case (avs_address)
            `FDO_OFS_DIG_OUT:  rdata_q <= {24'h00_0000, dig_out_q};
            `FDO_OFS_CFG_CTL:  rdata_q <= {30'h0000_0000, rate_q};
            `FDO_OFS_RATE_SEL: rdata_q <= {30'h0000_0000, rate_q};
            `FDO_OFS_CFG:  rdata_q <= {24'h00_0000, cfg_q};
            `FDO_OFS_HEAD: rdata_q <= {29'h0000_0000, head_q};
            `FDO_OFS_STAT: rdata_q <= {25'h000_0000, pins_q};
            default:       rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_readdata = rdata_q;

   // digital_output_reg
   always_ff @(posedge clk) begin
      if (reset)
         dig_out_q <= `FDO_DIG_OUT_RST;
      else if (wr_go && lane0 && avs_address == `FDO_OFS_DIG_OUT)
         dig_out_q <= avs_writedata[7:0];
   end

   // a write without the low byte lane must leave the register alone
   AST_BE_IGNORED: assert property (@(posedge clk) disable iff (reset)
      (avs_write && !lane0) |=> $stable(dig_out_q))
      else $error("write without lane 0 changed the output register");

   // read data was captured in the wait cycle, so it shows the value of one edge back
   AST_READ_OUT: assert property (@(posedge clk) disable iff (reset)
      (avs_read && !avs_waitrequest && avs_address == `FDO_OFS_DIG_OUT) |->
      (avs_readdata == {24'h00_0000, $past(dig_out_q)}))
      else $error("output register read back wrong");

   // disk_controller configuration: polarity and four-drive encoding
   always_ff @(posedge clk) begin
      if (reset)
         cfg_q <= `FDO_CFG_RST;
      else if (wr_go && lane0 && avs_address == `FDO_OFS_CFG)
         cfg_q <= avs_writedata[7:0];
   end

   // one rate store shared by both rate registers, so the last write wins
   always_ff @(posedge clk) begin
      if (reset)
         rate_q <= `FDO_RATE_RST;
      else if (wr_go && lane0 &&
               (avs_address == `FDO_OFS_CFG_CTL || avs_address == `FDO_OFS_RATE_SEL))
         rate_q <= avs_writedata[1:0];
   end

   // head control written by the sequencer firmware
   always_ff @(posedge clk) begin
      if (reset)
         head_q <= `FDO_HEAD_RST;
      else if (wr_go && lane0 && avs_address == `FDO_OFS_HEAD)
         head_q <= avs_writedata[2:0];
   end

   fdo_drive_decode u_decode (
      .dig_out (dig_out_q),
      .enc4  (cfg_q[`FDO_CFG_ENC4]),
      .sel_n (sel_n),
      .mtr_n (mtr_n)
   );

   // direction only means something while seeking; read or write forces it idle
   assign dir_n = !(head_q[`FDO_HEAD_SEEK] && head_q[`FDO_HEAD_IN]
                    && !head_q[`FDO_HEAD_RW]);

   always_comb begin
      pins_d                     = fdo_pkg::FDO_PINS_IDLE;
      pins_d.drive_select_outs_n = sel_n;
      pins_d.motor_outs_n        = mtr_n;
      pins_d.density_select_out  = is_high_rate(rate_q)
                                   == cfg_q[`FDO_CFG_DENS_POL];
      pins_d.head_dir_n          = dir_n;
      pins_d.rate_bit0_out       = rate_q[0];
   end

   // output flops keep the cable glitch free while registers settle
   always_ff @(posedge clk) begin
      if (reset)
         pins_q <= fdo_pkg::FDO_PINS_IDLE;
      else
         pins_q <= pins_d;
   end

   assign pins = pins_q;

   // checks on the pins against their causes, and on the single wait cycle
   AST_RATE_CTL: assert property (@(posedge clk) disable iff (reset)
      (wr_go && lane0 && avs_address == `FDO_OFS_CFG_CTL) |=> ##1
      (pins.rate_bit0_out == $past(avs_writedata[0], 2)))
      else $error("rate bit missed a write to the control register");

   AST_RATE_SEL: assert property (@(posedge clk) disable iff (reset)
      (wr_go && lane0 && avs_address == `FDO_OFS_RATE_SEL) |=> ##1
      (pins.rate_bit0_out == $past(avs_writedata[0], 2)))
      else $error("rate bit missed a write to the rate select register");

   AST_DENSITY: assert property (@(posedge clk) disable iff (reset)
      (wr_go && lane0 && avs_address == `FDO_OFS_CFG_CTL
       && avs_writedata[1:0] == 2'h2 && !cfg_q[`FDO_CFG_DENS_POL]) |=> ##1
      pins.density_select_out)
      else $error("density pin wrong for low rate with inverted sense");

   AST_DENS_POL: assert property (@(posedge clk) disable iff (reset)
      $changed(cfg_q[`FDO_CFG_DENS_POL]) && $stable(rate_q) |=>
      $changed(pins.density_select_out))
      else $error("polarity change did not flip density pin");

   AST_DIR_IN: assert property (@(posedge clk) disable iff (reset)
      (head_q == 3'h3) |=> !pins.head_dir_n)
      else $error("direction not asserted for an inward seek");

   AST_DIR_OUT: assert property (@(posedge clk) disable iff (reset)
      (head_q[`FDO_HEAD_SEEK] && !head_q[`FDO_HEAD_IN]) |=> pins.head_dir_n)
      else $error("direction asserted for an outward seek");

   AST_DIR_RW: assert property (@(posedge clk) disable iff (reset)
      head_q[`FDO_HEAD_RW] [*2] |-> pins.head_dir_n)
      else $error("direction active during read or write");

   AST_SEL_NORM: assert property (@(posedge clk) disable iff (reset)
      (!cfg_q[`FDO_CFG_ENC4] && dig_out_q[1:0] == 2'h1) |=>
      (pins.drive_select_outs_n == 2'h1))
      else $error("drive 1 select not decoded");

   AST_SEL_ENC: assert property (@(posedge clk) disable iff (reset)
      cfg_q[`FDO_CFG_ENC4] |=>
      (pins.drive_select_outs_n == ~$past(dig_out_q[1:0])))
      else $error("encoded drive number wrong");

   AST_RESET_IDLE: assert property (@(posedge clk)
      reset |=> (pins == fdo_pkg::FDO_PINS_IDLE))
      else $error("pins not idle after reset");

   AST_WAIT_ONE: assert property (@(posedge clk) disable iff (reset)
      avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held longer than one cycle");

   // the release edge still loads idle pins, so these attempts start only out of reset
   AST_SEL_DRV0: assert property (@(posedge clk) disable iff (reset)
      (!reset && !cfg_q[`FDO_CFG_ENC4] && dig_out_q[1:0] == 2'h0) |=>
      (pins.drive_select_outs_n == 2'h2))
      else $error("drive 0 select not decoded");

   AST_SEL_NONE: assert property (@(posedge clk) disable iff (reset)
      (!reset && !cfg_q[`FDO_CFG_ENC4] && dig_out_q[1]) |=>
      (pins.drive_select_outs_n == 2'h3))
      else $error("select driven for a drive without a select line");

   AST_MTR_ENC: assert property (@(posedge clk) disable iff (reset)
      (!reset && cfg_q[`FDO_CFG_ENC4]) |=>
      (pins.motor_outs_n == {2{!$past(dig_out_q[`FDO_DIG_OUT_MTR_LO + dig_out_q[1:0]])}}))
      else $error("encoded motor lines wrong");

   AST_DENS_HIGH: assert property (@(posedge clk) disable iff (reset)
      (!reset && rate_q == `FDO_RATE_1M && cfg_q[`FDO_CFG_DENS_POL]) |=>
      pins.density_select_out)
      else $error("density pin low for the top rate with plain sense");

endmodule : fdo_drive_ctrl
`default_nettype wire

// ### fdo_drive_model.sv
// Purpose: drives on the cable, seen from their side
// Assumes: selects and motor lines are active low
// Notes:   passive listener, it never drives the cable
`default_nettype none
module fdo_drive_model (
   // cable from the controller
   input  wire fdo_pkg::fdo_pins_t pins,
   // what the drives see
   output logic [1:0]              drive_active,
   output logic                    step_inward
);
   timeunit 1ns;
   timeprecision 1ps;
   // a drive only listens while its select is low; encoded mode is not decoded here
   always_comb begin
      drive_active = ~pins.drive_select_outs_n;
      step_inward  = ~pins.head_dir_n;
   end
endmodule : fdo_drive_model
`default_nettype wire

// ### fdo_drive_ctrl_tb.sv
// Purpose: self-checking bench of the drive cable outputs
// Assumes: one access at a time, pins settle one edge after the register
// Notes:   expected pins come from a shadow of the written registers
`default_nettype none
`include "fdo_defines.svh"
module fdo_drive_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, avs_read, avs_write, avs_waitrequest, step_inward;
   logic [4:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rdv;
   logic [7:0]  dig_out, cfg;
   logic [1:0]  rate;
   logic [2:0]  head;
   fdo_pkg::fdo_pins_t pins;
   int compares, miscompares, cycles;

   fdo_drive_ctrl fdo_drive_ctrl_i (.clk(clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pins(pins));
   fdo_drive_model fdo_drive_model_i (.pins(pins), .drive_active(), .step_inward(step_inward));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // pins expected from the shadow registers
   function automatic logic [6:0] ep();
      logic [1:0] s;
      logic [1:0] m;
      s = (dig_out[1:0] == 2'h0) ? 2'h2 : (dig_out[1:0] == 2'h1) ? 2'h1 : 2'h3;
      m = ~dig_out[5:4];
      if (cfg[7]) begin
         s = ~dig_out[1:0];
         m = {2{~dig_out[4 + dig_out[1:0]]}};
      end
      return {s, m, ((rate == 2'h0) || (rate == 2'h3)) == cfg[5], head != 3'h3, rate[0]};
   endfunction : ep

   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one access; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic [4:0] a, input logic [31:0] d, input logic w, input logic be);
      logic wt;
      @(posedge clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= {3'h0, be};
      avs_write      <= w;
      avs_read       <= ~w;
      // sampled at the rising edge itself, before that edge's updates land
      do begin
         @(posedge clk);
         wt  = avs_waitrequest;
         rdv = avs_readdata;
      end while (wt !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   // write, update the shadow, then compare every pin once settled
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic be);
      bus(a, d, 1'b1, be);
      if (be) case (a)
         `FDO_OFS_DIG_OUT: dig_out = d[7:0];
         `FDO_OFS_CFG_CTL, `FDO_OFS_RATE_SEL: rate = d[1:0];
         `FDO_OFS_CFG: cfg = d[7:0];
         `FDO_OFS_HEAD: head = d[2:0];
         default: ;
      endcase
      @(posedge clk);
      @(negedge clk);
      chk({25'h0, pins}, {25'h0, ep()});
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      bus(a, 32'h0, 1'b0, 1'b1);
      chk(rdv, exp);
   endtask : rd

   // release reset and reload the shadow; density and the drive 0 select need one edge after release
   task automatic unreset();
      @(posedge clk);
      reset <= 1'b0;
      {dig_out, cfg, rate, head} =
         {`FDO_DIG_OUT_RST, `FDO_CFG_RST, `FDO_RATE_RST, `FDO_HEAD_RST};
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({25'h0, pins}, {25'h0, ep()});
   endtask : unreset

   // cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      {avs_address, avs_read, avs_write, avs_byteenable, avs_writedata} = '0;
      {reset, cycles, compares, miscompares} = {1'b1, 96'h0};
      repeat (3) @(posedge clk);
      unreset();
      rd(`FDO_OFS_CFG, {24'h0, `FDO_CFG_RST});
      rd(5'h18, 32'h0);
      $display("test reset done");
      for (int e = 0; e < 2; e++)
         for (int dv = 0; dv < 4; dv++) begin
            wr(`FDO_OFS_CFG, {24'h0, e[0], 7'h20}, 1'b1);
            wr(`FDO_OFS_DIG_OUT, {24'h0, 4'h5 << dv[1], 2'h0, dv[1:0]}, 1'b1);
         end
      $display("test select done");
      for (int p = 0; p < 2; p++)
         for (int r = 0; r < 4; r++) begin
            wr(`FDO_OFS_CFG, {26'h0, p[0], 5'h0}, 1'b1);
            wr(`FDO_OFS_CFG_CTL, {30'h0, r[1:0]}, 1'b1);
         end
      wr(`FDO_OFS_CFG_CTL, 32'h1, 1'b1);
      wr(`FDO_OFS_RATE_SEL, 32'h2, 1'b1);
      rd(`FDO_OFS_CFG_CTL, 32'h2);
      wr(`FDO_OFS_CFG_CTL, 32'h3, 1'b1);
      rd(`FDO_OFS_RATE_SEL, 32'h3);
      $display("test rate done");
      for (int h = 0; h < 8; h++) begin
         wr(`FDO_OFS_HEAD, {29'h0, h[2:0]}, 1'b1);
         chk({31'h0, step_inward}, {31'h0, h == 3});
      end
      $display("test head done");
      wr(`FDO_OFS_DIG_OUT, 32'h31, 1'b1);
      wr(`FDO_OFS_DIG_OUT, 32'h0, 1'b0);
      rd(`FDO_OFS_DIG_OUT, 32'h31);
      wr(`FDO_OFS_STAT, 32'h7F, 1'b1);
      rd(`FDO_OFS_STAT, {25'h0, ep()});
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk({25'h0, pins}, {25'h0, fdo_pkg::FDO_PINS_IDLE});
      unreset();
      rd(`FDO_OFS_DIG_OUT, 32'h0);
      $display("test refusal and reset done");
      wrap_up();
   end
endmodule : fdo_drive_ctrl_tb
`default_nettype wire
